// ==== quad_serial_flash_pkg.sv ====
/*
  Shared constants and types of the quad-lane serial flash reader.
  Assumes it is compiled before every other file of the block.
*/
package quad_serial_flash_pkg;

  // Datapath widths
  localparam int WORD_W = 128;
  localparam int LEN_W = 7;
  localparam int CNT_W = 12;
  localparam int DIV_W = 8;
  localparam int LANE_W = 4;
  localparam int FIFO_DEPTH = 8;

  // Lane modes
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;

  // Pin configurations
  localparam logic [1:0] PIN_3 = 2'h0;
  localparam logic [1:0] PIN_4 = 2'h1;
  localparam logic [1:0] PIN_6 = 2'h2;

  // Bits moved per falling edge
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h4;

  // Smallest usable divider: a zero divider behaves as one
  localparam logic [DIV_W-1:0] DIV_MIN = 8'h01;

  // Top bit index of the word, used to left-align transmit data
  localparam logic [LEN_W-1:0] LEN_TOP = 7'h7F;

  // Frame sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_SHIFT = 5'h04,
    ST_PUSH = 5'h08,
    ST_TAIL = 5'h10
  } state_type;

endpackage : quad_serial_flash_pkg

// ==== stream_if.sv ====
/*
  Valid/ready word stream between the sequencer and its FIFO.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface stream_if #(parameter int W = 128) ();
  logic valid;          // Word offered
  logic ready;          // Word accepted
  logic [W-1:0] data;   // Word contents

  // Producer side
  modport src (output valid, output data, input ready);
  // Consumer side
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== word_fifo.sv ====
/*
  Synchronous FIFO of received words with valid/ready on both sides.
  Assumes a synchronised active-low reset and a shared clock enable.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int W = 128,
  parameter int DEPTH = 8
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Streams
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  // Depth at pointer width, so the fill compare stays unsigned and narrow
  localparam logic [AW:0] DEPTH_N = (AW+1)'(DEPTH);

  // Pointers carry one wrap bit beyond the address
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_type;

  fifo_state_type q_ff;
  fifo_state_type nxt_q;
  logic [W-1:0] mem [DEPTH];  // Word storage
  logic full;
  logic empty;
  logic [AW:0] fill_n;        // Words held, modulo the pointer wrap

  // Full when addresses match and wrap bits differ
  assign full = (q_ff.wp[AW-1:0] == q_ff.rp[AW-1:0]) &&
                (q_ff.wp[AW] != q_ff.rp[AW]);
  assign empty = (q_ff.wp == q_ff.rp);
  assign fill_n = q_ff.wp - q_ff.rp;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[q_ff.rp[AW-1:0]];

  // Pointer advance on each handshake
  always_comb begin
    nxt_q = q_ff;
    if (wr.valid && !full) begin
      nxt_q.wp = q_ff.wp + 1'b1;
    end
    if (rd.ready && !empty) begin
      nxt_q.rp = q_ff.rp + 1'b1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // Storage write
  always_ff @(posedge clk_i) begin
    if (ce_i && wr.valid && !full) begin
      mem[q_ff.wp[AW-1:0]] <= wr.data;
    end
  end

  // Guard against a pointer running past the other
  fifo_bound_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    fill_n <= DEPTH_N)
    else $error("fifo holds more words than its depth");

endmodule : word_fifo

// ==== quad_serial_flash_master.sv ====
/*
  Quad-lane serial flash reader: frame sequencer, clock divider, lane
  shifters and a buffered read window for received words.
  Assumes configuration inputs come from logic on core_clk_i and are
  stable while busy_o is high; data lanes come from pins.
*/
`timescale 1ns/1ps

// Operation
// - Always master: drives clock and select
// - Reads over one, two or four lanes
// - Host reads words through a window
// - Word length programmable 1 to 128
// - Exactly programmed word count per frame
// - Three, four or six pin wiring
// - Selectable word and frame done events
// - Zero to three periods before data
// - Clock idles low, phase zero
// - Input lanes sampled on falling edge
// - Select active delay-plus-one periods early
// - Select drops two or more periods after last, once the last word is taken
// - Output lane changes on falling edges
// - First bit one period before fall
// - Even divider above zero gives uneven duty
module quad_serial_flash_master (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Frame configuration
  input wire logic start_i,
  input wire logic [1:0] lane_mode_i,
  input wire logic [1:0] pin_mode_i,
  input wire logic [6:0] word_len_i,
  input wire logic [11:0] word_count_i,
  input wire logic [1:0] cs_delay_field_i,
  input wire logic [7:0] clock_divide_value_i,
  input wire logic irq_word_en_i,
  input wire logic irq_frame_en_i,
  input wire logic [127:0] tx_word_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  input wire logic [3:0] dq_i,
  // Read window
  output logic rd_valid_o,
  output logic [127:0] rd_data_o,
  input wire logic rd_ready_i,
  // Status and events
  output logic busy_o,
  output logic irq_word_o,
  output logic irq_frame_o
);

  // Whole state of the sequencer
  typedef struct packed {
    quad_serial_flash_pkg::state_type st;
    logic [1:0] lanes;      // Effective lane mode
    logic [1:0] pins;       // Pin configuration
    logic [7:0] per_m1;     // Period length minus one
    logic [6:0] len_m1;     // Word length minus one
    logic [11:0] cnt_m1;    // Word count minus one
    logic [1:0] dly;        // Select-to-data periods
    logic [7:0] ph;         // Cycle within period
    logic [1:0] lead;       // Lead periods left
    logic tail;             // Second tail period
    logic [7:0] rem;        // Bits left in word
    logic [11:0] words;     // Words done in frame
    logic [127:0] rx;       // Receive shifter
    logic [127:0] tx;       // Transmit shifter
    logic [3:0] s1;         // Lane sync, first stage
    logic [3:0] s2;         // Lane sync, second stage
    logic sclk;
    logic cs_n;
    logic dq0;
    logic oe0;
    logic busy;
    logic irq_w;
    logic irq_f;
    logic push_v;           // Word waiting for the FIFO
    logic out_v;            // Window holds a word
    logic [127:0] out_d;    // Window word
  } master_state_type;

  master_state_type q_ff;
  master_state_type nxt_q;
  logic [1:0] rst_s_ff;     // Reset release synchroniser
  logic rst_n;              // Synchronised reset
  logic pop;                // Window takes a word

  stream_if #(.W(quad_serial_flash_pkg::WORD_W)) wr_if ();
  stream_if #(.W(quad_serial_flash_pkg::WORD_W)) rd_if ();

  // Release reset through two flip-flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s_ff <= 2'h0;
    end else begin
      rst_s_ff <= {rst_s_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_s_ff[1];

  // Word buffer between shifter and read window
  word_fifo #(
    .W(quad_serial_flash_pkg::WORD_W),
    .DEPTH(quad_serial_flash_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .wr(wr_if),
    .rd(rd_if)
  );
  assign wr_if.valid = q_ff.push_v;
  assign wr_if.data = q_ff.rx;
  assign pop = rd_if.valid && (!q_ff.out_v || rd_ready_i);
  assign rd_if.ready = pop;

  // Left-align a word so its top bit leaves first
  function automatic logic [127:0] align_tx(input logic [127:0] w,
                                            input logic [6:0] lm1);
    align_tx = w << (quad_serial_flash_pkg::LEN_TOP - lm1);
  endfunction : align_tx

  // Period arithmetic
  logic [8:0] per;          // Period in core cycles
  logic [8:0] low_len;      // Low phase length
  logic ph_end;             // Last cycle of a period
  logic [7:0] ph_nx;        // Next cycle index
  logic [2:0] step;         // Bits per falling edge
  logic [3:0] in_bits;      // Sampled lane bits
  logic [127:0] rx_sh;      // Receiver after one edge
  logic [2:0] extra;        // Surplus bits in last edge
  logic last_edge;          // Word ends at this edge
  logic [1:0] eff_lanes;    // Lane mode allowed by wiring
  logic single_out;         // Output lane in use

  assign per = {1'b0, q_ff.per_m1} + 9'h001;
  assign low_len = per - {1'b0, per[8:1]};
  assign ph_end = (q_ff.ph == q_ff.per_m1);
  assign ph_nx = ph_end ? 8'h00 : q_ff.ph + 8'h01;

  // Quad needs six pins, dual four; else single
  always_comb begin
    eff_lanes = quad_serial_flash_pkg::LANE_SINGLE;
    if (lane_mode_i == quad_serial_flash_pkg::LANE_QUAD &&
        pin_mode_i == quad_serial_flash_pkg::PIN_6) begin
      eff_lanes = quad_serial_flash_pkg::LANE_QUAD;
    end else if (lane_mode_i != quad_serial_flash_pkg::LANE_SINGLE &&
                 pin_mode_i != quad_serial_flash_pkg::PIN_3) begin
      eff_lanes = quad_serial_flash_pkg::LANE_DUAL;
    end
  end
  assign single_out = (eff_lanes == quad_serial_flash_pkg::LANE_SINGLE)
                      && (pin_mode_i != quad_serial_flash_pkg::PIN_3);

  // Lane selection; higher lane carries the higher bit
  always_comb begin
    case (q_ff.lanes)
      quad_serial_flash_pkg::LANE_QUAD: begin
        step = quad_serial_flash_pkg::STEP_4;
        in_bits = q_ff.s2;
      end
      quad_serial_flash_pkg::LANE_DUAL: begin
        step = quad_serial_flash_pkg::STEP_2;
        in_bits = {2'h0, q_ff.s2[1:0]};
      end
      default: begin
        step = quad_serial_flash_pkg::STEP_1;
        // Three-pin wiring reads back on lane zero
        in_bits = (q_ff.pins == quad_serial_flash_pkg::PIN_3) ?
                  {3'h0, q_ff.s2[0]} : {3'h0, q_ff.s2[1]};
      end
    endcase
  end
  assign rx_sh = (q_ff.rx << step) | {124'h0, in_bits};
  assign last_edge = ({5'h00, step} >= q_ff.rem);
  assign extra = step - q_ff.rem[2:0];

  // Sequencer next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = dq_i;
    nxt_q.s2 = q_ff.s1;
    nxt_q.irq_w = 1'b0;
    nxt_q.irq_f = 1'b0;
    // Word handed to the FIFO
    if (q_ff.push_v && wr_if.ready) begin
      nxt_q.push_v = 1'b0;
    end
    case (q_ff.st)
      quad_serial_flash_pkg::ST_IDLE: begin
        nxt_q.sclk = 1'b0;
        if (start_i) begin
          // Latch configuration and assert select
          nxt_q.lanes = eff_lanes;
          nxt_q.pins = pin_mode_i;
          nxt_q.per_m1 = (clock_divide_value_i <
                          quad_serial_flash_pkg::DIV_MIN) ?
                         quad_serial_flash_pkg::DIV_MIN :
                         clock_divide_value_i;
          nxt_q.len_m1 = word_len_i;
          nxt_q.cnt_m1 = word_count_i;
          nxt_q.dly = cs_delay_field_i;
          nxt_q.lead = cs_delay_field_i;
          nxt_q.cs_n = 1'b0;
          nxt_q.busy = 1'b1;
          nxt_q.ph = 8'h00;
          nxt_q.words = 12'h000;
          nxt_q.rx = '0;
          nxt_q.rem = {1'b0, word_len_i} + 8'h01;
          nxt_q.tx = align_tx(tx_word_i, word_len_i);
          nxt_q.oe0 = single_out;
          if (cs_delay_field_i == 2'h0) begin
            // No delay: data with select
            nxt_q.dq0 = nxt_q.tx[127];
            nxt_q.st = quad_serial_flash_pkg::ST_SHIFT;
          end else begin
            nxt_q.dq0 = 1'b0;
            nxt_q.st = quad_serial_flash_pkg::ST_LEAD;
          end
        end
      end
      quad_serial_flash_pkg::ST_LEAD: begin
        // Clock held low for the programmed periods
        nxt_q.ph = ph_nx;
        if (ph_end) begin
          nxt_q.lead = q_ff.lead - 2'h1;
          if (q_ff.lead == 2'h1) begin
            nxt_q.dq0 = q_ff.tx[127];
            nxt_q.st = quad_serial_flash_pkg::ST_SHIFT;
          end
        end
      end
      quad_serial_flash_pkg::ST_SHIFT: begin
        nxt_q.ph = ph_nx;
        nxt_q.sclk = ({1'b0, ph_nx} >= low_len);
        if (ph_end) begin
          // Falling edge: sample lanes, advance output
          nxt_q.tx = q_ff.tx << 1;
          nxt_q.dq0 = q_ff.tx[126];
          if (last_edge) begin
            nxt_q.rx = rx_sh >> extra;
            nxt_q.push_v = 1'b1;
            nxt_q.irq_w = irq_word_en_i;
            if (q_ff.words == q_ff.cnt_m1) begin
              nxt_q.oe0 = 1'b0;
              nxt_q.tail = 1'b0;
              nxt_q.st = quad_serial_flash_pkg::ST_TAIL;
            end else begin
              nxt_q.st = quad_serial_flash_pkg::ST_PUSH;
            end
          end else begin
            nxt_q.rx = rx_sh;
            nxt_q.rem = q_ff.rem - {5'h00, step};
          end
        end
      end
      quad_serial_flash_pkg::ST_PUSH: begin
        // Clock paused low until the FIFO takes the word
        if (wr_if.ready) begin
          nxt_q.words = q_ff.words + 12'h001;
          nxt_q.rx = '0;
          nxt_q.rem = {1'b0, q_ff.len_m1} + 8'h01;
          nxt_q.tx = align_tx(tx_word_i, q_ff.len_m1);
          nxt_q.dq0 = nxt_q.tx[127];
          nxt_q.ph = 8'h00;
          nxt_q.st = quad_serial_flash_pkg::ST_SHIFT;
        end
      end
      quad_serial_flash_pkg::ST_TAIL: begin
        // Two idle periods and the last word taken, then release select
        nxt_q.ph = ph_nx;
        if (ph_end) begin
          nxt_q.tail = 1'b1;
          if (q_ff.tail && !q_ff.push_v) begin
            nxt_q.cs_n = 1'b1;
            nxt_q.busy = 1'b0;
            nxt_q.irq_f = irq_frame_en_i;
            nxt_q.st = quad_serial_flash_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_q.st = quad_serial_flash_pkg::ST_IDLE;
      end
    endcase
    // Read window stage
    if (pop) begin
      nxt_q.out_v = 1'b1;
      nxt_q.out_d = rd_if.data;
    end else if (rd_ready_i) begin
      nxt_q.out_v = 1'b0;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
      q_ff.st <= quad_serial_flash_pkg::ST_IDLE;
      q_ff.cs_n <= 1'b1;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign sclk_o = q_ff.sclk;
  assign cs_n_o = q_ff.cs_n;
  assign dq_o = {3'h0, q_ff.dq0};
  assign dq_oe_o = {3'h0, q_ff.oe0};
  assign rd_valid_o = q_ff.out_v;
  assign rd_data_o = q_ff.out_d;
  assign busy_o = q_ff.busy;
  assign irq_word_o = q_ff.irq_w;
  assign irq_frame_o = q_ff.irq_f;

  // Helper counters watched by the assertions
  logic [11:0] lead_cyc;
  logic lead_done;
  logic [8:0] hi_cyc;
  logic [11:0] tail_cyc;
  logic [12:0] push_n;
  logic [11:0] lead_exp;
  assign lead_exp = 12'(({10'h000, q_ff.dly} + 12'h001) *
                        {3'h0, per});

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lead_cyc <= 12'h000;
      lead_done <= 1'b0;
      hi_cyc <= 9'h000;
      tail_cyc <= 12'h000;
      push_n <= 13'h0000;
    end else if (ce_i) begin
      lead_cyc <= q_ff.cs_n ? 12'h000 : lead_cyc + 12'h001;
      lead_done <= !q_ff.cs_n && (lead_done || !q_ff.sclk && hi_cyc != 0);
      hi_cyc <= q_ff.sclk ? hi_cyc + 9'h001 : 9'h000;
      tail_cyc <= (q_ff.st == quad_serial_flash_pkg::ST_TAIL) ?
                  tail_cyc + 12'h001 : 12'h000;
      if (q_ff.st == quad_serial_flash_pkg::ST_IDLE) begin
        push_n <= 13'h0000;
      end else if (wr_if.valid && wr_if.ready) begin
        push_n <= push_n + 13'h0001;
      end
    end
  end

  idle_clock_low_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    q_ff.cs_n |-> !q_ff.sclk)
    else $error("clock not low while deselected");

  lead_periods_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $fell(q_ff.sclk) && !lead_done |-> lead_cyc == lead_exp)
    else $error("first falling edge at wrong distance from select");

  duty_high_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $fell(q_ff.sclk) |-> hi_cyc == {1'b0, per[8:1]})
    else $error("clock high phase has wrong length");

  tail_periods_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $rose(q_ff.cs_n) |-> tail_cyc >= {2'h0, per, 1'b0})
    else $error("select released before two periods");

  frame_words_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $rose(q_ff.cs_n) |-> push_n == {1'b0, q_ff.cnt_m1} + 13'h0001)
    else $error("frame ended with wrong word count");

  out_on_fall_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    q_ff.st == quad_serial_flash_pkg::ST_SHIFT &&
    $past(q_ff.st) == quad_serial_flash_pkg::ST_SHIFT &&
    $changed(q_ff.dq0) |-> $fell(q_ff.sclk))
    else $error("output lane moved off a falling edge");

  push_after_fall_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $rose(q_ff.push_v) |-> $past(q_ff.sclk) && !q_ff.sclk)
    else $error("word captured away from a falling edge");

  three_pin_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    q_ff.pins == quad_serial_flash_pkg::PIN_3 || q_ff.cs_n |->
    q_ff.oe0 == 1'b0)
    else $error("lane driven in three-pin wiring or when idle");

  word_event_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    q_ff.irq_w |-> $rose(q_ff.push_v))
    else $error("word event without a finished word");

  frame_done_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(q_ff.irq_f));
  quad_read_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    q_ff.lanes == quad_serial_flash_pkg::LANE_QUAD && q_ff.push_v);
  fifo_stall_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    q_ff.st == quad_serial_flash_pkg::ST_PUSH && !wr_if.ready);
  long_lead_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    q_ff.dly == 2'h3 && $fell(q_ff.sclk) && !lead_done);

endmodule : quad_serial_flash_master

// ==== flash_slave_model.sv ====
/*
  Behavioural serial flash that streams a fixed pattern, MSB first.
  Assumes a mode 0 clock from the master and a lane count from the bench.
*/
`timescale 1ns/1ps
module flash_slave_model #(
  parameter logic [127:0] PATTERN = 128'h0
) (
  // Serial pins from the master
  input wire logic sclk_i,
  input wire logic cs_n_i,
  // Active lanes: 1, 2 or 4
  input wire logic [2:0] lanes_i,
  // Lanes toward the master
  output logic [3:0] dq_o
);
  logic [127:0] shift_ff; // Next bits at the top
  logic [3:0] drive;      // Value for the selected state

  // Reload at every select
  initial shift_ff = PATTERN;
  always @(negedge cs_n_i) shift_ff = PATTERN;

  // Launch the next bits on each falling clock edge
  always @(negedge sclk_i) begin
    if (!cs_n_i) begin
      shift_ff = (shift_ff << lanes_i) | (shift_ff >> (128 - lanes_i));
    end
  end

  // Lane map: quad dq3 highest, dual dq1 higher, single on every lane
  always_comb begin
    if (lanes_i == 3'h4) drive = shift_ff[127:124];
    else if (lanes_i == 3'h2) drive = {2{shift_ff[127:126]}};
    else drive = {4{shift_ff[127]}};
    // Released lanes show no stale value
    dq_o = cs_n_i ? ~drive : drive;
  end
endmodule : flash_slave_model

// ==== quad_serial_flash_master_bench.sv ====
/*
  Frame-level testbench of the serial flash reader.
  Assumes the design files and the flash model are compiled first.
*/
`timescale 1ns/1ps
module quad_serial_flash_master_bench;
  localparam logic [127:0] PAT = 128'hC3A5_0F96_E187_4B2D_9C3E_71F0_5AA5_D24B;
  // Design inputs
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, rd_ready = 1'b1;
  logic ce = 1'b1;
  logic [1:0] lane_mode = 2'h0, pin_mode = 2'h0, cs_dly = 2'h0;
  logic [6:0] word_len = 7'h00;
  logic [11:0] word_count = 12'h000;
  logic [7:0] div_v = 8'h03;
  logic irq_w = 1'b0, irq_f = 1'b0;
  logic [127:0] tx_word = 128'hF0F0_1234_5678_9ABC_DEF0_0F0F_A5A5_3C3C;
  // Design outputs
  logic sclk_o, cs_n_o, busy_o, rd_valid_o, irq_word_o, irq_frame_o;
  logic [3:0] dq_o, dq_oe_o, dq_i;
  logic [127:0] rd_data_o;
  logic [2:0] lanes_m = 3'h1;
  // Monitor state
  int cyc, t_cs, t_end, t_rise, t_first, t_last, hi_w, n_falls;
  int n_iw, n_if, bad_dq, bad_idle, bad_count, cmp_count;
  logic cs_p = 1'b1, sclk_p = 1'b0, dq_p = 1'b0, oe_first;
  logic [127:0] rq[$];
  logic [127:0] tx_cap;  // Output lane bits seen at each falling edge

  // 50 MHz clock
  always #10 clk = ~clk;

  quad_serial_flash_master u_quad_serial_flash_master (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .start_i(start),
    .lane_mode_i(lane_mode), .pin_mode_i(pin_mode),
    .word_len_i(word_len), .word_count_i(word_count),
    .cs_delay_field_i(cs_dly), .clock_divide_value_i(div_v),
    .irq_word_en_i(irq_w), .irq_frame_en_i(irq_f), .tx_word_i(tx_word),
    .sclk_o(sclk_o), .cs_n_o(cs_n_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dq_i(dq_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .rd_ready_i(rd_ready), .busy_o(busy_o), .irq_word_o(irq_word_o),
    .irq_frame_o(irq_frame_o));

  flash_slave_model #(.PATTERN(PAT)) u_flash_slave_model (
    .sclk_i(sclk_o), .cs_n_i(cs_n_o), .lanes_i(lanes_m), .dq_o(dq_i));

  // Edge times, event counts and window transfers, seen before each edge
  always @(posedge clk) begin
    cyc++;
    if (rd_valid_o === 1'b1 && rd_ready === 1'b1 && ce === 1'b1)
      rq.push_back(rd_data_o);
    if (cs_p && !cs_n_o) t_cs = cyc;
    if (!cs_p && cs_n_o) t_end = cyc;
    if (!sclk_p && sclk_o) t_rise = cyc;
    if (sclk_p && !sclk_o) begin
      if (n_falls == 0) begin
        t_first = cyc;
        oe_first = dq_oe_o[0];
      end
      n_falls++;
      tx_cap = {tx_cap[126:0], dq_p};
      t_last = cyc;
      hi_w = cyc - t_rise;
    end
    // Output lane must hold while the clock is high
    if (sclk_p && sclk_o && dq_o[0] !== dq_p) bad_dq++;
    if (cs_n_o && sclk_o !== 1'b0) bad_idle++;
    if (irq_word_o === 1'b1) n_iw++;
    if (irq_frame_o === 1'b1) n_if++;
    cs_p = cs_n_o;
    sclk_p = sclk_o;
    dq_p = dq_o[0];
  end

  // Count one comparison, report a mismatch
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // One frame: configure, start, optionally stall the window, then compare
  task automatic run_frame(input logic [1:0] lm, input logic [1:0] pm,
    input int len, input int cnt, input int dly, input int div,
    input bit iw, input bit ifr, input bit fill);
    int lanes, steps, per, k, rot, waitc;
    logic [127:0] w;
    lanes = (lm == 2'h2 && pm == 2'h2) ? 4 :
            (lm == 2'h1 && pm != 2'h0) ? 2 : 1;
    steps = (len + lanes - 1) / lanes;
    per = (div == 0 ? 1 : div) + 1;
    lanes_m = 3'(lanes);
    rq.delete();
    n_falls = 0;
    n_iw = 0;
    n_if = 0;
    bad_dq = 0;
    rd_ready <= !fill;
    lane_mode <= lm;
    pin_mode <= pm;
    word_len <= 7'(len - 1);
    word_count <= 12'(cnt - 1);
    cs_dly <= 2'(dly);
    div_v <= 8'(div);
    irq_w <= iw;
    irq_f <= ifr;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1 check(busy_o === 1'b1, "busy not raised");
    if (fill) begin
      // Window and FIFO fill up, the frame must wait
      repeat (600) @(posedge clk);
      check(busy_o === 1'b1 && rd_valid_o === 1'b1, "no stall");
      // Enable low: the window must not drain and the frame must not end
      ce <= 1'b0;
      rd_ready <= 1'b1;
      repeat (12) @(posedge clk);
      check(busy_o === 1'b1 && rq.size() == 0, "not frozen");
      ce <= 1'b1;
    end
    waitc = 0;
    while (busy_o !== 1'b0 && waitc < 20000) begin
      @(posedge clk);
      waitc++;
    end
    if (waitc >= 20000) begin
      check(1'b0, "frame hang");
      stop_test();
    end
    repeat (8) @(posedge clk);
    check(rq.size() == cnt, "word count");
    for (k = 0; k < rq.size() && k < cnt; k++) begin
      rot = (k * steps * lanes) % 128;
      w = (PAT << rot) | (PAT >> (128 - rot));
      w = w >> (128 - len);
      check(rq[k] === w, "word data");
    end
    check(n_falls == cnt * steps, "edge count");
    check(t_first - t_cs == (dly + 1) * per, "lead time");
    if (!fill) check(t_end - t_last == 2 * per, "tail time");
    check(hi_w == per / 2, "high phase");
    check(oe_first === (lanes == 1 && pm != 2'h0), "lane enable");
    // Last word sent on the output lane, top bit first
    if (lanes == 1 && pm != 2'h0)
      check(((tx_cap ^ tx_word) << (128 - len)) == 128'h0, "sent bits");
    check(n_iw == (iw ? cnt : 0), "word events");
    check(n_if == (ifr ? 1 : 0), "frame events");
    check(bad_dq == 0 && bad_idle == 0, "clock or lane");
  endtask : run_frame

  // Reset, then frames across lane modes, pin modes, delays and dividers
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run_frame(2'h0, 2'h0, 8, 3, 0, 3, 1, 1, 0);
    run_frame(2'h0, 2'h1, 1, 2, 3, 4, 1, 0, 0);
    run_frame(2'h1, 2'h1, 13, 2, 1, 5, 0, 1, 0);
    run_frame(2'h2, 2'h2, 128, 2, 2, 3, 1, 1, 0);
    run_frame(2'h2, 2'h0, 5, 1, 0, 6, 0, 0, 0);
    run_frame(2'h0, 2'h1, 4, 10, 0, 3, 1, 1, 1);
    // Reset in mid-frame: pins drop at once, next frame runs clean
    start <= 1'b1;
    repeat (20) @(posedge clk);
    start <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk);
    check(cs_n_o === 1'b1 && busy_o === 1'b0 && sclk_o === 1'b0, "reset");
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run_frame(2'h1, 2'h2, 6, 2, 0, 7, 0, 0, 0);
    stop_test();
  end
endmodule : quad_serial_flash_master_bench
